// ---- rtl/uvf_consts.svh ----
`ifndef UVF_CONSTS_SVH
`define UVF_CONSTS_SVH

// Command codes of the fault response bytes
`define UVF_CMD_OC_RESP      8'h47
`define UVF_CMD_UV_RESP      8'h4b
`define UVF_CMD_TONMAX_RESP  8'h63

// Reset and factory values of the response bytes
`define UVF_OC_RESP_RST      8'h00
`define UVF_UV_RESP_RST      8'h00
`define UVF_TONMAX_RESP_RST  8'hb8

// Field positions inside a response byte
`define UVF_RESP_HI          7
`define UVF_RESP_LO          6
`define UVF_RETRY_HI         5
`define UVF_RETRY_LO         3
`define UVF_DELAY_HI         2
`define UVF_DELAY_LO         0

// Response field encodings
`define UVF_RESP_IGNORE      2'h0
`define UVF_RESP_DEGLITCH    2'h1
`define UVF_RESP_SHUTDOWN    2'h2
`define UVF_RESP_BAD         2'h3
`define UVF_RETRY_NONE       3'h0

// Data bytes carried by every response command
`define UVF_RESP_NBYTES      4'h1

// Timing at a 5 ns clock
`define UVF_CLK_PERIOD_PS    5000
`define UVF_DELAY_STEP_US    10
`define UVF_DELAY_STEP_CYC   ((`UVF_DELAY_STEP_US * 1000000) / `UVF_CLK_PERIOD_PS)
`define UVF_US_CYC           (1000000 / `UVF_CLK_PERIOD_PS)

`endif

// ---- rtl/uvf_pkg.sv ----
package uvf_pkg;

  // Fault response sequencer states
  typedef enum logic [1:0] {
    UVF_ST_RUN,
    UVF_ST_DEGLITCH,
    UVF_ST_LATCHED_OFF,
    UVF_ST_RETRY_WAIT
  } uvf_state_t;

endpackage

// ---- rtl/uvf_fault_resp.sv ----
`timescale 1ns/1ps
`include "uvf_consts.svh"

module uvf_fault_resp
  import uvf_pkg::*;
#(
  parameter int unsigned DELAY_STEP_CYC = `UVF_DELAY_STEP_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Command port from the serial interface
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic [3:0]  cmd_nbytes,
  input  wire logic        cmd_page,
  output logic             cmd_rvalid,
  output logic      [7:0]  cmd_rdata,
  // Global commands, one-cycle pulses
  input  wire logic        clear_faults_cmd,
  input  wire logic        restore_user_all_cmd,
  input  wire logic        store_user_all_cmd,
  input  wire logic        device_soft_reset_cmd,
  // Channel control and sequencing state
  input  wire logic        chan_on_cmd,
  input  wire logic        ton_delay_done,
  input  wire logic        ton_rise_done,
  input  wire logic        ton_rise_active,
  input  wire logic        toff_fall_active,
  input  wire logic        ton_max_elapsed,
  input  wire logic        vout_above_uv,
  input  wire logic        oc_present,
  input  wire logic        latchoff_fault,
  input  wire logic [15:0] retry_interval_cfg,
  // Raw comparators
  input  wire logic        uv_fault_raw,
  input  wire logic        uv_warn_raw,
  input  wire logic        ton_max_fault_raw,
  // Alert masks
  input  wire logic        uv_alert_mask,
  input  wire logic        tonmax_alert_mask,
  input  wire logic        cml_alert_mask,
  // Channel outputs
  output logic             chan_enable,
  output logic             uv_detect_masked,
  output logic             uv_warn_event,
  // Status bits
  output logic             status_byte_nota,
  output logic             status_word_vout,
  output logic             status_vout_uv_fault,
  output logic             status_vout_tonmax_fault,
  output logic             status_cml_fault,
  // Open-drain alert pin
  output logic             alert_out,
  output logic             alert_oe
);

  // Response bytes, live and nonvolatile copies
  logic [7:0]  oc_cfg_reg [2];          // Overcurrent byte per page
  logic [7:0]  oc_nv_reg [2];           // Stored overcurrent bytes
  logic [7:0]  uv_cfg_reg;              // Undervoltage byte
  logic [7:0]  uv_nv_reg;               // Stored undervoltage byte
  logic [7:0]  tonmax_cfg_reg;          // Timeout byte
  logic [7:0]  tonmax_nv_reg;           // Stored timeout byte
  logic [7:0]  act_cfg_reg;             // Undervoltage byte of the fault in progress

  // Sequencer
  uvf_state_t  state_reg;               // Response state
  uvf_state_t  state_next;              // Next response state
  logic [23:0] count_reg;               // Delay or retry countdown
  logic [23:0] count_next;              // Next countdown
  logic        on_dly_reg;              // Last run command
  logic        crossed_reg;             // Output has reached UV limit
  logic        uv_alert_reg;            // Alert cause, undervoltage
  logic        tonmax_alert_reg;        // Alert cause, timeout
  logic        cml_alert_reg;           // Alert cause, bad command

  // Decoded events
  logic        off_on_edge;             // Off-then-on command seen
  logic        clr_faults;              // Any status clearing event
  logic        uv_event;                // Unmasked undervoltage fault
  logic        tonmax_event;            // Enabled timeout fault
  logic        resp_wr;                 // Well-formed response write
  logic        cml_event;               // Malformed or bad command

  // Retry decision shared by the timeout, shutdown and deglitch paths
  function automatic uvf_state_t retry_state(input logic [7:0] cfg);
    retry_state = (cfg[`UVF_RETRY_HI:`UVF_RETRY_LO] == `UVF_RETRY_NONE) ?
                  UVF_ST_LATCHED_OFF : UVF_ST_RETRY_WAIT;
  endfunction

  // Deglitch length in cycles from a delay field
  function automatic logic [23:0] delay_cycles(input logic [7:0] cfg);
    delay_cycles = 24'(cfg[`UVF_DELAY_HI:`UVF_DELAY_LO] * DELAY_STEP_CYC);
  endfunction

  // Command is one of the response bytes
  function automatic logic is_resp_code(input logic [7:0] code);
    is_resp_code = (code == `UVF_CMD_OC_RESP) || (code == `UVF_CMD_UV_RESP) ||
                   (code == `UVF_CMD_TONMAX_RESP);
  endfunction

  // Off-then-on detection on the combined run command
  always_ff @(posedge clock) begin
    on_dly_reg <= reset ? 1'b0 : chan_on_cmd;
  end

  assign off_on_edge = chan_on_cmd & ~on_dly_reg;
  assign clr_faults  = clear_faults_cmd | off_on_edge | restore_user_all_cmd |
                       device_soft_reset_cmd;

  // Output reaches the UV limit once per start; lost when inactive
  always_ff @(posedge clock) begin
    if (reset) begin
      crossed_reg <= 1'b0;
    end else if (!chan_enable) begin
      crossed_reg <= 1'b0;
    end else if (vout_above_uv) begin
      crossed_reg <= 1'b1;
    end
  end

  // Detection mask, built from the start-up criteria
  always_comb begin
    uv_detect_masked = ~(ton_max_elapsed & ton_delay_done & ton_rise_done &
                         crossed_reg & ~oc_present);
    if (!chan_enable) begin
      uv_detect_masked = 1'b1;
    end
    if (ton_rise_active || toff_fall_active) begin
      uv_detect_masked = 1'b1;
    end
  end

  assign uv_event      = uv_fault_raw & ~uv_detect_masked;
  assign uv_warn_event = uv_warn_raw & ~uv_detect_masked;
  assign tonmax_event  = ton_max_fault_raw & chan_enable & (tonmax_cfg_reg != 8'h00);

  // Command legality; a bad write is ignored and flagged
  always_comb begin
    resp_wr   = 1'b0;
    cml_event = 1'b0;
    if (cmd_valid) begin
      if (!is_resp_code(cmd_code)) begin
        // Not a code this block answers
        cml_event = 1'b1;
      end else if (cmd_nbytes != `UVF_RESP_NBYTES) begin
        cml_event = 1'b1;
      end else if (cmd_write && cmd_code == `UVF_CMD_UV_RESP &&
                   cmd_wdata[`UVF_RESP_HI:`UVF_RESP_LO] == `UVF_RESP_BAD) begin
        cml_event = 1'b1;
      end else if (cmd_write && cmd_code == `UVF_CMD_OC_RESP &&
                   cmd_wdata[`UVF_RESP_HI:`UVF_RESP_LO] == `UVF_RESP_DEGLITCH) begin
        // Overcurrent has no plain deglitch encoding
        cml_event = 1'b1;
      end else begin
        // Reads leave the bytes alone
        resp_wr = cmd_write;
      end
    end
  end

  // Live response bytes; restore and soft reset reload stored copies
  always_ff @(posedge clock) begin
    if (reset) begin
      oc_cfg_reg[0]  <= `UVF_OC_RESP_RST;
      oc_cfg_reg[1]  <= `UVF_OC_RESP_RST;
      uv_cfg_reg     <= `UVF_UV_RESP_RST;
      tonmax_cfg_reg <= `UVF_TONMAX_RESP_RST;
    end else if (restore_user_all_cmd || device_soft_reset_cmd) begin
      oc_cfg_reg[0]  <= oc_nv_reg[0];
      oc_cfg_reg[1]  <= oc_nv_reg[1];
      uv_cfg_reg     <= uv_nv_reg;
      tonmax_cfg_reg <= tonmax_nv_reg;
    end else if (resp_wr) begin
      unique case (cmd_code)
        `UVF_CMD_OC_RESP: oc_cfg_reg[cmd_page] <= cmd_wdata;
        `UVF_CMD_UV_RESP: uv_cfg_reg <= cmd_wdata;
        default:          tonmax_cfg_reg <= cmd_wdata;
      endcase
    end
  end

  // Nonvolatile copies; kept over soft reset, only reset here at power-up
  always_ff @(posedge clock) begin
    if (reset) begin
      oc_nv_reg[0]  <= `UVF_OC_RESP_RST;
      oc_nv_reg[1]  <= `UVF_OC_RESP_RST;
      uv_nv_reg     <= `UVF_UV_RESP_RST;
      tonmax_nv_reg <= `UVF_TONMAX_RESP_RST;
    end else if (store_user_all_cmd) begin
      oc_nv_reg[0]  <= oc_cfg_reg[0];
      oc_nv_reg[1]  <= oc_cfg_reg[1];
      uv_nv_reg     <= uv_cfg_reg;
      tonmax_nv_reg <= tonmax_cfg_reg;
    end
  end

  // Read answers one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_rvalid <= 1'b0;
      cmd_rdata  <= 8'h00;
    end else begin
      cmd_rvalid <= cmd_valid & ~cmd_write & ~cml_event;
      unique case (cmd_code)
        `UVF_CMD_OC_RESP:     cmd_rdata <= oc_cfg_reg[cmd_page];
        `UVF_CMD_UV_RESP:     cmd_rdata <= uv_cfg_reg;
        `UVF_CMD_TONMAX_RESP: cmd_rdata <= tonmax_cfg_reg;
        default:              cmd_rdata <= 8'h00;
      endcase
    end
  end

  // Response sequencer; latches the byte at the fault so rewrites wait
  always_comb begin
    state_next = state_reg;
    count_next = (count_reg != 24'h0) ? count_reg - 24'h1 : count_reg;
    if (latchoff_fault) begin
      // Another fault forbids restart
      state_next = UVF_ST_LATCHED_OFF;
    end else begin
      unique case (state_reg)
        UVF_ST_RUN: begin
          if (tonmax_event) begin
            state_next = retry_state(tonmax_cfg_reg);
            count_next = 24'(retry_interval_cfg * `UVF_US_CYC);
          end else if (uv_event) begin
            unique case (uv_cfg_reg[`UVF_RESP_HI:`UVF_RESP_LO])
              `UVF_RESP_IGNORE: state_next = UVF_ST_RUN;
              `UVF_RESP_DEGLITCH: begin
                state_next = UVF_ST_DEGLITCH;
                count_next = delay_cycles(uv_cfg_reg);
              end
              default: begin
                state_next = retry_state(uv_cfg_reg);
                count_next = 24'(retry_interval_cfg * `UVF_US_CYC);
              end
            endcase
          end
        end
        UVF_ST_DEGLITCH: begin
          if (!chan_on_cmd || !uv_fault_raw) begin
            // Fault went away in time
            state_next = UVF_ST_RUN;
          end else if (count_reg == 24'h0) begin
            state_next = retry_state(act_cfg_reg);
            count_next = 24'(retry_interval_cfg * `UVF_US_CYC);
          end
        end
        UVF_ST_LATCHED_OFF: begin
          if (!chan_on_cmd) begin
            state_next = UVF_ST_RUN;
          end
        end
        UVF_ST_RETRY_WAIT: begin
          if (!chan_on_cmd || count_reg == 24'h0) begin
            state_next = UVF_ST_RUN;
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (reset || device_soft_reset_cmd) begin
      state_reg <= UVF_ST_RUN;
      count_reg <= 24'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Undervoltage byte in force for the fault being handled
  always_ff @(posedge clock) begin
    if (reset) begin
      act_cfg_reg <= `UVF_UV_RESP_RST;
    end else if (state_reg == UVF_ST_RUN && uv_event) begin
      act_cfg_reg <= uv_cfg_reg;
    end
  end

  // Output allowed while running or riding out a deglitch
  assign chan_enable = chan_on_cmd &
                       (state_reg == UVF_ST_RUN || state_reg == UVF_ST_DEGLITCH);

  // Sticky status bits; a new fault beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      status_vout_uv_fault     <= 1'b0;
      status_vout_tonmax_fault <= 1'b0;
      status_cml_fault         <= 1'b0;
    end else begin
      status_vout_uv_fault     <= uv_event | (status_vout_uv_fault & ~clr_faults);
      status_vout_tonmax_fault <= tonmax_event | (status_vout_tonmax_fault & ~clr_faults);
      status_cml_fault         <= cml_event | (status_cml_fault & ~clr_faults);
    end
  end

  // Summary bits follow the UV and timeout detail bits, not the CML bit
  // Summary bits for VOUT faults
  assign status_word_vout = status_vout_uv_fault | status_vout_tonmax_fault;
  assign status_byte_nota = status_word_vout;

  // Alert causes; masked faults never pull the line
  always_ff @(posedge clock) begin
    if (reset) begin
      uv_alert_reg     <= 1'b0;
      tonmax_alert_reg <= 1'b0;
      cml_alert_reg    <= 1'b0;
    end else begin
      uv_alert_reg     <= (uv_event & ~uv_alert_mask) | (uv_alert_reg & ~clr_faults);
      tonmax_alert_reg <= (tonmax_event & ~tonmax_alert_mask) |
                          (tonmax_alert_reg & ~clr_faults);
      cml_alert_reg    <= (cml_event & ~cml_alert_mask) | (cml_alert_reg & ~clr_faults);
    end
  end

  // Open-drain: only ever pulls low
  assign alert_out = 1'b0;
  assign alert_oe  = uv_alert_reg | tonmax_alert_reg | cml_alert_reg;

endmodule // uvf_fault_resp

// ---- dv/uvf_fault_resp_checker.sv ----
`timescale 1ns/1ps
`include "uvf_consts.svh"

// Port watcher for the fault response block
module uvf_fault_resp_checker (
  // Clock and reset
  input wire logic       clock, reset,
  // Command port
  input wire logic       cmd_valid, cmd_write, cmd_rvalid,
  input wire logic [7:0] cmd_code, cmd_wdata,
  input wire logic [3:0] cmd_nbytes,
  // Sequencing and comparators
  input wire logic       ton_delay_done, ton_rise_done, ton_max_elapsed,
  input wire logic       ton_rise_active, toff_fall_active, oc_present,
  input wire logic       uv_fault_raw, ton_max_fault_raw, uv_alert_mask,
  // Channel and status outputs
  input wire logic       chan_enable, uv_detect_masked, alert_oe,
  input wire logic       status_byte_nota, status_word_vout, status_cml_fault,
  input wire logic       status_vout_uv_fault, status_vout_tonmax_fault
);
  // One domain, so one clock and reset for all
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // Write of the unsupported response code
  sequence uv_bad_wr;
    cmd_valid && cmd_write && cmd_nbytes == `UVF_RESP_NBYTES &&
      cmd_code == `UVF_CMD_UV_RESP && cmd_wdata[7:6] == `UVF_RESP_BAD;
  endsequence
  // Undervoltage while detection is open; timeout wins a tie
  sequence uv_hit;
    uv_fault_raw && !uv_detect_masked && !ton_max_fault_raw;
  endsequence
  // Well-formed read of the overcurrent byte
  sequence oc_rd;
    cmd_valid && !cmd_write && cmd_nbytes == `UVF_RESP_NBYTES &&
      cmd_code == `UVF_CMD_OC_RESP;
  endsequence

  AST_UV_BITS: assert property (uv_hit |=>
    status_vout_uv_fault && status_word_vout && status_byte_nota)
    else $error("UV fault bits not set");
  // Mask is taken at the detecting edge, hence the past value
  AST_UV_ALERT: assert property (
    $rose(status_vout_uv_fault) && !$past(uv_alert_mask) |-> alert_oe)
    else $error("UV alert missing");
  AST_START_MASK: assert property (
    !(ton_max_elapsed && ton_delay_done && ton_rise_done) || oc_present
      |-> uv_detect_masked)
    else $error("UV open before startup done");
  AST_IDLE_MASK: assert property (!chan_enable |-> uv_detect_masked)
    else $error("UV open while inactive");
  AST_RAMP_MASK: assert property (
    ton_rise_active || toff_fall_active |-> uv_detect_masked)
    else $error("UV open during a ramp");
  AST_CML_WR: assert property (uv_bad_wr |=> status_cml_fault)
    else $error("Bad UV write not flagged");
  AST_TON_BITS: assert property (
    $rose(status_vout_tonmax_fault) |-> status_word_vout && status_byte_nota &&
      $past(ton_max_fault_raw) && $past(chan_enable))
    else $error("Timeout summary bits not set");
  AST_NBYTES: assert property (
    cmd_valid && cmd_nbytes != `UVF_RESP_NBYTES |=> status_cml_fault && !cmd_rvalid)
    else $error("Wrong byte count accepted");
  AST_OC_READ: assert property (oc_rd |=> cmd_rvalid)
    else $error("Overcurrent byte read not answered");
endmodule // uvf_fault_resp_checker

bind uvf_fault_resp uvf_fault_resp_checker i_chk (
  .clock, .reset, .cmd_valid, .cmd_write, .cmd_rvalid, .cmd_code, .cmd_wdata,
  .cmd_nbytes, .ton_delay_done, .ton_rise_done, .ton_max_elapsed, .ton_rise_active,
  .toff_fall_active, .oc_present, .uv_fault_raw, .ton_max_fault_raw, .uv_alert_mask,
  .chan_enable, .uv_detect_masked, .alert_oe, .status_byte_nota, .status_word_vout,
  .status_cml_fault, .status_vout_uv_fault, .status_vout_tonmax_fault
);

// ---- dv/uvf_host_model.sv ----
`timescale 1ns/1ps

// Host side of the command port
module uvf_host_model (
  // Clock
  input  wire logic       clock,
  // Request toward the channel
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata,
  output logic [3:0]      cmd_nbytes,
  output logic            cmd_page,
  // Answer from the channel
  input  wire logic       cmd_rvalid,
  input  wire logic [7:0] cmd_rdata
);
  // Page for the next request, chosen by the bench
  logic page_sel = 1'h0;

  // Idle port at time zero
  initial begin
    {cmd_valid, cmd_write, cmd_page} = 3'h0;
    {cmd_code, cmd_wdata, cmd_nbytes} = 20'h0;
  end

  // One request; answer looked for over three cycles
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      input logic [3:0] n, output logic rv, output logic [7:0] rd);
    rv = 1'h0;
    rd = 8'h00;
    @(negedge clock);
    cmd_valid = 1'h1;
    cmd_write = w;
    cmd_code = c;
    cmd_page = page_sel;
    cmd_wdata = d;
    cmd_nbytes = n;
    @(negedge clock);
    cmd_valid = 1'h0;
    // Released data shows its inverse, not a stale copy
    cmd_wdata = ~d;
    repeat (3) begin
      if (cmd_rvalid === 1'h1) begin
        rv = 1'h1;
        rd = cmd_rdata;
      end
      @(negedge clock);
    end
  endtask
endmodule // uvf_host_model

// ---- dv/test_uvf_fault_resp.sv ----
`timescale 1ns/1ps

// Self-checking bench of the fault response block
module test_uvf_fault_resp;
  // Table row: request beside expected answer
  typedef struct packed {
    logic w; logic [7:0] code; logic [7:0] data; logic [3:0] nb;
    logic rv; logic [7:0] rd; logic cml;
  } uvf_row_t;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        cmd_valid, cmd_write, cmd_page, cmd_rvalid;
  logic [7:0]  cmd_code, cmd_wdata, cmd_rdata;
  logic [3:0]  cmd_nbytes;
  logic        clear_faults_cmd, restore_user_all_cmd, store_user_all_cmd;
  logic        device_soft_reset_cmd, chan_on_cmd, ton_delay_done, ton_rise_done;
  logic        ton_rise_active, toff_fall_active, ton_max_elapsed, vout_above_uv;
  logic        oc_present, latchoff_fault, uv_fault_raw, uv_warn_raw, ton_max_fault_raw;
  logic        uv_alert_mask, tonmax_alert_mask, cml_alert_mask;
  logic [15:0] retry_interval_cfg;
  logic        chan_enable, uv_detect_masked, uv_warn_event, status_byte_nota;
  logic        status_word_vout, status_vout_uv_fault, status_vout_tonmax_fault;
  logic        status_cml_fault, alert_out, alert_oe, rv;
  logic [7:0]  rd;
  int          err_total = 0;
  int          total_checks = 0;
  int          n;
  // Command port cases
  uvf_row_t rows [10] = '{
    '{1'h0, 8'h47, 8'h00, 4'h1, 1'h1, 8'h00, 1'h0},
    '{1'h0, 8'h63, 8'h00, 4'h1, 1'h1, 8'hb8, 1'h0},
    '{1'h1, 8'h47, 8'hc0, 4'h1, 1'h0, 8'h00, 1'h0},
    '{1'h0, 8'h47, 8'h00, 4'h1, 1'h1, 8'hc0, 1'h0},
    '{1'h1, 8'h47, 8'h40, 4'h1, 1'h0, 8'h00, 1'h1},
    '{1'h1, 8'h4b, 8'hc0, 4'h1, 1'h0, 8'h00, 1'h1},
    '{1'h0, 8'h4b, 8'h00, 4'h1, 1'h1, 8'h00, 1'h0},
    '{1'h0, 8'h47, 8'h00, 4'h2, 1'h0, 8'h00, 1'h1},
    '{1'h1, 8'h4b, 8'h80, 4'h0, 1'h0, 8'h00, 1'h1},
    '{1'h0, 8'h55, 8'h00, 4'h1, 1'h0, 8'h00, 1'h1}
  };

  // Free-running 200 MHz clock
  always #2.5 clock = ~clock;

  uvf_fault_resp #(.DELAY_STEP_CYC(4)) i_dut (.clock, .reset, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .cmd_nbytes, .cmd_page, .cmd_rvalid, .cmd_rdata,
    .clear_faults_cmd, .restore_user_all_cmd, .store_user_all_cmd, .device_soft_reset_cmd,
    .chan_on_cmd, .ton_delay_done, .ton_rise_done, .ton_rise_active, .toff_fall_active,
    .ton_max_elapsed, .vout_above_uv, .oc_present, .latchoff_fault, .retry_interval_cfg,
    .uv_fault_raw, .uv_warn_raw, .ton_max_fault_raw, .uv_alert_mask, .tonmax_alert_mask,
    .cml_alert_mask, .chan_enable, .uv_detect_masked, .uv_warn_event, .status_byte_nota,
    .status_word_vout, .status_vout_uv_fault, .status_vout_tonmax_fault,
    .status_cml_fault, .alert_out, .alert_oe);
  uvf_host_model i_host (.clock, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .cmd_nbytes, .cmd_page, .cmd_rvalid, .cmd_rdata);

  // Compare, count, report
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  // One-cycle clear event: 0 clear, 1 restore, 2 soft reset
  task clr(input int k);
    {clear_faults_cmd, restore_user_all_cmd, device_soft_reset_cmd} = 3'h4 >> k;
    tick(1);
    {clear_faults_cmd, restore_user_all_cmd, device_soft_reset_cmd} = 3'h0;
  endtask
  task uv(input int k);
    uv_fault_raw = 1'h1;
    tick(k);
    uv_fault_raw = 1'h0;
  endtask
  task conclude;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for an enable level; n counts cycles
  task wait_en(input logic v, input int lim);
    n = 0;
    while (chan_enable !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("Error chan_enable wait expected %h seen %h", v, chan_enable);
      conclude();
    end
  endtask

  initial begin
    {clear_faults_cmd, restore_user_all_cmd, store_user_all_cmd, device_soft_reset_cmd} = 4'h0;
    {chan_on_cmd, ton_delay_done, ton_rise_done, ton_rise_active, toff_fall_active} = 5'h0;
    {ton_max_elapsed, vout_above_uv, oc_present, latchoff_fault, uv_fault_raw} = 5'h0;
    {uv_warn_raw, ton_max_fault_raw, uv_alert_mask, tonmax_alert_mask, cml_alert_mask} = 5'h0;
    retry_interval_cfg = 16'h0001;
    tick(2);
    reset = 1'h0;
    chk("reset status", 16'h0, {status_vout_uv_fault, status_cml_fault, alert_oe});
    chk("idle mask", 16'h1, uv_detect_masked);
    foreach (rows[i]) begin
      i_host.xfer(rows[i].w, rows[i].code, rows[i].data, rows[i].nb, rv, rd);
      chk("rvalid", rows[i].rv, rv);
      if (rows[i].rv) chk("rdata", rows[i].rd, rd);
      chk("cml", {2{rows[i].cml}}, {status_cml_fault, alert_oe});
      clr(0);
    end
    // Second page, then store and restore of the stored copy
    i_host.page_sel = 1'h1;
    i_host.xfer(1'h1, 8'h47, 8'h80, 4'h1, rv, rd);
    i_host.xfer(1'h0, 8'h47, 8'h00, 4'h1, rv, rd);
    chk("page1", 16'h180, {rv, rd});
    store_user_all_cmd = 1'h1;
    tick(1);
    store_user_all_cmd = 1'h0;
    i_host.xfer(1'h1, 8'h47, 8'h00, 4'h1, rv, rd);
    clr(1);
    i_host.xfer(1'h0, 8'h47, 8'h00, 4'h1, rv, rd);
    chk("stored", 16'h180, {rv, rd});
    i_host.page_sel = 1'h0;
    // Masked communication fault keeps the line released
    cml_alert_mask = 1'h1;
    i_host.xfer(1'h0, 8'h55, 8'h00, 4'h1, rv, rd);
    chk("cml masked", 16'h2, {status_cml_fault, alert_oe});
    cml_alert_mask = 1'h0;
    clr(0);
    // Startup gating, overcurrent and ramps
    chan_on_cmd = 1'h1;
    uv_warn_raw = 1'h1;
    tick(2);
    chk("early mask", 16'h2, {uv_detect_masked, uv_warn_event});
    {ton_delay_done, ton_rise_done, ton_max_elapsed, vout_above_uv, oc_present} = 5'h1f;
    tick(2);
    chk("oc mask", 16'h1, uv_detect_masked);
    {oc_present, ton_rise_active} = 2'h1;
    tick(1);
    chk("rise mask", 16'h1, uv_detect_masked);
    {ton_rise_active, toff_fall_active} = 2'h1;
    tick(1);
    chk("fall mask", 16'h1, uv_detect_masked);
    toff_fall_active = 1'h0;
    tick(1);
    chk("open", 16'h1, {uv_detect_masked, uv_warn_event});
    // Ignore response: reports, keeps running
    uv(1);
    chk("uv bits", 16'h1e, {status_vout_uv_fault, status_word_vout, status_byte_nota, alert_oe,
        alert_out});
    tick(5);
    chk("ignore", 16'h3, {chan_enable, status_vout_uv_fault});
    clr(1);
    chk("restored", 16'h0, {status_vout_uv_fault, alert_oe});
    uv_alert_mask = 1'h1;
    uv(1);
    chk("masked alert", 16'h2, {status_vout_uv_fault, alert_oe});
    uv_alert_mask = 1'h0;
    clr(0);
    // Shutdown with no retry, then off-on clears
    i_host.xfer(1'h1, 8'h4b, 8'h80, 4'h1, rv, rd);
    uv(1);
    wait_en(1'h0, 3);
    tick(20);
    chk("stays off", 16'h0, chan_enable);
    chan_on_cmd = 1'h0;
    tick(2);
    chan_on_cmd = 1'h1;
    tick(2);
    chk("off on", 16'h2, {chan_enable, status_vout_uv_fault});
    // Deglitch of three steps, glitch first
    i_host.xfer(1'h1, 8'h4b, 8'h43, 4'h1, rv, rd);
    uv(4);
    tick(20);
    chk("glitch rides", 16'h1, chan_enable);
    uv_fault_raw = 1'h1;
    wait_en(1'h0, 40);
    uv_fault_raw = 1'h0;
    chk("deglitch", 16'h1, 16'(n >= 12 && n <= 15));
    chan_on_cmd = 1'h0;
    tick(2);
    chan_on_cmd = 1'h1;
    // Continuous retry spaced by one microsecond
    i_host.xfer(1'h1, 8'h4b, 8'hb8, 4'h1, rv, rd);
    uv(1);
    wait_en(1'h0, 3);
    wait_en(1'h1, 300);
    chk("retry gap", 16'h1, 16'(n >= 198 && n <= 202));
    // Another fault forbids any further restart
    latchoff_fault = 1'h1;
    tick(2);
    latchoff_fault = 1'h0;
    tick(5);
    chk("latched", 16'h0, chan_enable);
    clr(2);
    chk("soft reset", 16'h0, {status_vout_uv_fault, alert_oe});
    // Timeout fault, then its response disabled
    ton_max_fault_raw = 1'h1;
    tick(1);
    ton_max_fault_raw = 1'h0;
    chk("ton bits", 16'hf, {status_vout_tonmax_fault, status_word_vout, status_byte_nota, alert_oe});
    wait_en(1'h1, 300);
    clr(0);
    i_host.xfer(1'h1, 8'h63, 8'h00, 4'h1, rv, rd);
    ton_max_fault_raw = 1'h1;
    tick(1);
    ton_max_fault_raw = 1'h0;
    tick(2);
    chk("ton off", 16'h1, {status_vout_tonmax_fault, chan_enable});
    conclude();
  end
endmodule // test_uvf_fault_resp
